// ---- core/idl_pkg.sv ----
// Notes on behaviour
// RL1: Divide returns low 32 quotient bits, no remainder.
// RL2: Unsigned divide treats both operands unsigned.
// RL3: Divide flag updates depend on record/overflow forms.
// RL4: Logical ops bitwise; immediate zero-extended or shifted.
// RL5: Record bit updates condition field zero.
// RL6: Logical ops leave exception register unchanged.
// RL7: Logical destination is first operand field.
// RL8: AND, AND-complement, NAND with both record forms.
// RL9: AND immediates always record; shifted uses upper half.
// RL10: OR, OR-complement, NOR with both record forms.
// RL11: OR immediates never update condition field zero.
// RL12: XOR, equivalence; XOR immediates never record.
// RL13: Byte sign extension replicates bit 24 upward.
// RL14: Halfword sign extension replicates bit 16 upward.
// RL15: Count zeros from most significant bit.
// RL16: Recorded zero count forces less-than bit low.
// RL17: Compare writes less, greater, equal, summary copy.
// RL18: Compare target field selects condition field.
// RL19: Immediates signed algebraic, unsigned logical.
// RL20: Software codes compare length bit as zero.
// RL21: Algebraic compare signed, immediate sign-extended.
// RL22: Zero divide or overflow sets overflow flags.
package idl_pkg;

    // Data word and bus address
    typedef logic [31:0] idl_word_t;
    typedef logic [7:0] idl_addr_t;

    // Register offsets (byte addresses)
    localparam idl_addr_t OFS_SOURCE = 8'h00;
    localparam idl_addr_t OFS_SECOND = 8'h04;
    localparam idl_addr_t OFS_CONTROL = 8'h08;
    localparam idl_addr_t OFS_RESULT = 8'h0c;
    localparam idl_addr_t OFS_CONDITION = 8'h10;
    localparam idl_addr_t OFS_EXCEPTION = 8'h14;
    localparam idl_addr_t OFS_STATUS = 8'h18;

    // Exception register field positions (bit 0 of doc = bit 31 here)
    localparam int SUMMARY_POS = 31;
    localparam int OVERFLOW_POS = 30;

    // Reset values
    localparam idl_word_t WORD_RESET = 32'h0000_0000;

    // Divider iterations, one quotient bit per clock
    localparam logic [5:0] DIV_STEPS = 6'h20;

    // Operation codes
    typedef enum logic [4:0] {
        OP_DIVW = 5'h00, OP_DIVWU = 5'h01,
        OP_AND = 5'h02, OP_ANDI = 5'h03, OP_ANDIS = 5'h04,
        OP_ANDC = 5'h05, OP_NAND = 5'h06,
        OP_OR = 5'h07, OP_ORI = 5'h08, OP_ORIS = 5'h09,
        OP_ORC = 5'h0a, OP_NOR = 5'h0b,
        OP_XOR = 5'h0c, OP_XORI = 5'h0d, OP_XORIS = 5'h0e,
        OP_EQUIV = 5'h0f,
        OP_EXT_BYTE = 5'h10, OP_EXT_HALF = 5'h11,
        OP_COUNT_ZEROS = 5'h12,
        OP_CMP = 5'h13, OP_CMPI = 5'h14,
        OP_CMPL = 5'h15, OP_CMPLI = 5'h16
    } idl_op_e;

    // Control word carrier, low bits of the control register
    typedef struct packed {
        logic len_bit;
        logic [2:0] target_condition_field;
        logic overflow_enable;
        logic record_bit;
        logic [4:0] op;
    } idl_ctrl_s;

    localparam int CTRL_W = 11;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_DIVIDE = 3'b100
    } idl_state_e;

endpackage : idl_pkg

// ---- core/idl_unit.sv ----
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module idl_unit (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire idl_pkg::idl_addr_t wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire idl_pkg::idl_word_t wb_dat_i,
    output idl_pkg::idl_word_t wb_dat_o,
    output logic wb_ack_o,
    output logic busy_o
);
    import idl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Helper functions
    ////////////////////////////////////////////////////////////////////

    // Byte-lane merge for Wishbone writes
    function automatic idl_word_t lane_merge(input idl_word_t old_v,
                                             input idl_word_t new_v,
                                             input logic [3:0] sel);
        idl_word_t r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // Less, greater, equal, summary of a result
    function automatic logic [3:0] result_field(input idl_word_t v,
                                                input logic so);
        return {v[31], ~v[31] & (v != '0), v == '0, so};
    endfunction : result_field

    // Write one field; field 0 is the top nibble
    function automatic idl_word_t field_put(input idl_word_t cond,
                                            input logic [2:0] idx,
                                            input logic [3:0] nib);
        idl_word_t r;
        r = cond;
        r[(7 - idx) * 4 +: 4] = nib;
        return r;
    endfunction : field_put

    // Leading zeros counted from the most significant bit
    function automatic idl_word_t count_zeros(input idl_word_t v);
        idl_word_t n;
        logic hit;
        n = 32'h0000_0020;
        hit = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if (v[i] && !hit) begin
                n = idl_word_t'(31 - i);
                hit = 1'b1;
            end
        end
        return n;
    endfunction : count_zeros

    ////////////////////////////////////////////////////////////////////
    // Storage
    ////////////////////////////////////////////////////////////////////

    idl_word_t source_word; // Source operand register
    idl_word_t second_word; // Second operand or immediate (low 16)
    idl_ctrl_s cur; // Latched control word
    idl_word_t result_word; // Destination value
    idl_word_t condition_reg; // Eight 4-bit condition fields
    idl_word_t exception_reg; // Fixed-point exception bits
    idl_state_e state; // Sequencer state
    idl_state_e next_state;

    // Divider datapath
    idl_word_t div_quot; // Dividend shifts out, quotient shifts in
    logic [32:0] div_rem; // Partial remainder
    idl_word_t div_mag; // Divisor magnitude
    logic [5:0] div_count; // Steps done
    logic div_negate; // Quotient sign fix
    logic div_bad; // Zero divisor or signed overflow

    // Bus decode
    logic bus_req; // Fresh request this cycle
    logic bus_wr; // Fresh write
    logic ctrl_take; // Control write accepted
    idl_ctrl_s ctrl_new;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr = bus_req & wb_we_i;
    assign ctrl_new = idl_ctrl_s'(lane_merge(WORD_RESET, wb_dat_i,
                                             wb_sel_i)
                                  [CTRL_W-1:0]);
    // Busy unit drops new operations
    assign ctrl_take = bus_wr & (wb_adr_i == OFS_CONTROL)
                       & (state == ST_IDLE);

    ////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, unmapped reads return zero
    ////////////////////////////////////////////////////////////////////

    // One-cycle ack after each request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Read data captured with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= WORD_RESET;
        end else if (bus_req & ~wb_we_i) begin
            case (wb_adr_i)
                OFS_SOURCE: wb_dat_o <= source_word;
                OFS_SECOND: wb_dat_o <= second_word;
                OFS_CONTROL: wb_dat_o <= {21'h000000, cur};
                OFS_RESULT: wb_dat_o <= result_word;
                OFS_CONDITION: wb_dat_o <= condition_reg;
                OFS_EXCEPTION: wb_dat_o <= exception_reg;
                OFS_STATUS: wb_dat_o <= {31'h00000000, busy_o};
                default: wb_dat_o <= WORD_RESET;
            endcase
        end
    end

    // Operand registers, frozen while busy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            source_word <= WORD_RESET;
            second_word <= WORD_RESET;
        end else if (bus_wr && state == ST_IDLE) begin
            if (wb_adr_i == OFS_SOURCE) begin
                source_word <= lane_merge(source_word, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == OFS_SECOND) begin
                second_word <= lane_merge(second_word, wb_dat_i, wb_sel_i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    ////////////////////////////////////////////////////////////////////

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (ctrl_take) begin
                    if (ctrl_new.op == OP_DIVW || ctrl_new.op == OP_DIVWU) begin
                        next_state = ST_DIVIDE;
                    end else begin
                        next_state = ST_EXEC;
                    end
                end
            end
            ST_EXEC: next_state = ST_IDLE;
            ST_DIVIDE: begin
                if (div_count == DIV_STEPS) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // State, control latch and busy flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            cur <= '0;
            busy_o <= 1'b0;
        end else begin
            state <= next_state;
            busy_o <= (next_state != ST_IDLE);
            if (ctrl_take) begin
                cur <= ctrl_new;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Single-cycle operations
    ////////////////////////////////////////////////////////////////////

    idl_word_t imm_zero; // Zero-extended immediate
    idl_word_t imm_high; // Immediate in upper half
    idl_word_t imm_sign; // Sign-extended immediate
    idl_word_t next_result;
    logic write_dest; // Operation writes the destination
    logic record_upd; // Condition field zero is updated
    logic is_cmp; // Compare writes a selected field
    logic [3:0] cmp_nib;
    logic force_less_low; // Zero count clears the less bit

    assign imm_zero = {16'h0000, second_word[15:0]}; // RL4
    assign imm_high = {second_word[15:0], 16'h0000}; // RL4
    assign imm_sign = {{16{second_word[15]}}, second_word[15:0]};

    // Operation decode; destination is the first operand field
    always_comb begin
        next_result = WORD_RESET;
        write_dest = 1'b1; // RL7
        record_upd = cur.record_bit; // RL5
        is_cmp = 1'b0;
        cmp_nib = 4'h0;
        force_less_low = 1'b0;
        case (idl_op_e'(cur.op))
            OP_AND: next_result = source_word & second_word; // RL8
            OP_ANDC: next_result = source_word & ~second_word; // RL8
            OP_NAND: next_result = ~(source_word & second_word); // RL8
            OP_ANDI: begin
                next_result = source_word & imm_zero;
                record_upd = 1'b1; // RL9
            end
            OP_ANDIS: begin
                next_result = source_word & imm_high;
                record_upd = 1'b1; // RL9
            end
            OP_OR: next_result = source_word | second_word; // RL10
            OP_ORC: next_result = source_word | ~second_word; // RL10
            OP_NOR: next_result = ~(source_word | second_word); // RL10
            OP_ORI: begin
                next_result = source_word | imm_zero;
                record_upd = 1'b0; // RL11
            end
            OP_ORIS: begin
                next_result = source_word | imm_high;
                record_upd = 1'b0; // RL11
            end
            OP_XOR: next_result = source_word ^ second_word; // RL12
            OP_EQUIV: next_result = ~(source_word ^ second_word); // RL12
            OP_XORI: begin
                next_result = source_word ^ imm_zero;
                record_upd = 1'b0; // RL12
            end
            OP_XORIS: begin
                next_result = source_word ^ imm_high;
                record_upd = 1'b0; // RL12
            end
            OP_EXT_BYTE: begin
                next_result = {{24{source_word[7]}}, source_word[7:0]}; // RL13
            end
            OP_EXT_HALF: begin
                next_result = {{16{source_word[15]}},
                               source_word[15:0]}; // RL14
            end
            OP_COUNT_ZEROS: begin
                next_result = count_zeros(source_word); // RL15
                force_less_low = 1'b1; // RL16
            end
            OP_CMP: begin
                // Length bit ignored
                write_dest = 1'b0;
                record_upd = 1'b0;
                is_cmp = 1'b1;
                cmp_nib = {$signed(source_word) < $signed(second_word),
                           $signed(source_word) > $signed(second_word),
                           source_word == second_word,
                           exception_reg[SUMMARY_POS]}; // RL21
            end
            OP_CMPI: begin
                write_dest = 1'b0;
                record_upd = 1'b0;
                is_cmp = 1'b1;
                cmp_nib = {$signed(source_word) < $signed(imm_sign),
                           $signed(source_word) > $signed(imm_sign),
                           source_word == imm_sign,
                           exception_reg[SUMMARY_POS]}; // RL19
            end
            OP_CMPL: begin
                write_dest = 1'b0;
                record_upd = 1'b0;
                is_cmp = 1'b1;
                cmp_nib = {source_word < second_word,
                           source_word > second_word,
                           source_word == second_word,
                           exception_reg[SUMMARY_POS]}; // RL17
            end
            OP_CMPLI: begin
                write_dest = 1'b0;
                record_upd = 1'b0;
                is_cmp = 1'b1;
                cmp_nib = {source_word < imm_zero,
                           source_word > imm_zero,
                           source_word == imm_zero,
                           exception_reg[SUMMARY_POS]}; // RL19
            end
            default: begin
                // Divides and unknown codes: no-op here
                write_dest = 1'b0;
                record_upd = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Divider: restoring, one bit per clock, magnitudes then sign fix
    ////////////////////////////////////////////////////////////////////

    logic div_signed; // Signed variant selected
    logic [32:0] rem_shift; // Remainder after shift-in
    logic [32:0] rem_diff; // Trial subtraction
    idl_word_t div_final; // Quotient after sign fix
    logic div_done; // Last step reached
    logic next_summary; // Summary bit after this divide

    assign div_signed = (ctrl_new.op == OP_DIVWU) ? 1'b0 : 1'b1; // RL2
    assign rem_shift = {div_rem[31:0], div_quot[31]};
    assign rem_diff = rem_shift - {1'b0, div_mag};
    assign div_done = (state == ST_DIVIDE) && (div_count == DIV_STEPS);
    // Low word only, no remainder
    assign div_final = div_negate ? idl_word_t'(-div_quot)
                                  : div_quot; // RL1
    assign next_summary = exception_reg[SUMMARY_POS]
                          | (cur.overflow_enable & div_bad); // RL22

    // Load on start, then iterate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_quot <= WORD_RESET;
            div_rem <= 33'h000000000;
            div_mag <= WORD_RESET;
            div_count <= 6'h00;
            div_negate <= 1'b0;
            div_bad <= 1'b0;
        end else if (ctrl_take) begin
            div_rem <= 33'h000000000;
            div_count <= 6'h00;
            // Magnitudes for signed forms
            div_quot <= (div_signed & source_word[31])
                        ? idl_word_t'(-source_word) : source_word;
            div_mag <= (div_signed & second_word[31])
                       ? idl_word_t'(-second_word) : second_word;
            div_negate <= div_signed & (source_word[31] ^ second_word[31]);
            // Quotient undefined; flags only
            div_bad <= (second_word == WORD_RESET)
                       | (div_signed & (source_word == 32'h8000_0000)
                          & (second_word == 32'hffff_ffff)); // RL22
        end else if (state == ST_DIVIDE && !div_done) begin
            div_count <= div_count + 6'h01;
            if (!rem_diff[32]) begin
                div_rem <= rem_diff;
                div_quot <= {div_quot[30:0], 1'b1};
            end else begin
                div_rem <= rem_shift;
                div_quot <= {div_quot[30:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Architectural results
    ////////////////////////////////////////////////////////////////////

    // Destination register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_word <= WORD_RESET;
        end else if (state == ST_EXEC && write_dest) begin
            result_word <= next_result; // RL7
        end else if (div_done) begin
            result_word <= div_final; // RL1
        end
    end

    // Condition register; hardware beats bus write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            condition_reg <= WORD_RESET;
        end else if (state == ST_EXEC && is_cmp) begin
            condition_reg <= field_put(condition_reg,
                                       cur.target_condition_field,
                                       cmp_nib); // RL18
        end else if (state == ST_EXEC && record_upd) begin
            condition_reg <= field_put(condition_reg, 3'h0,
                                       result_field(next_result,
                                                    exception_reg[SUMMARY_POS])
                                       & {~force_less_low, 3'h7}); // RL16
        end else if (div_done && cur.record_bit) begin
            condition_reg <= field_put(condition_reg, 3'h0,
                                       result_field(div_final,
                                                    next_summary)); // RL3
        end else if (bus_wr && wb_adr_i == OFS_CONDITION) begin
            condition_reg <= lane_merge(condition_reg, wb_dat_i, wb_sel_i);
        end
    end

    // Exception register: logical ops never touch it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            exception_reg <= WORD_RESET;
        end else if (div_done && cur.overflow_enable) begin
            // Sticky summary; set beats a same-cycle clear
            exception_reg <= lane_merge(exception_reg, wb_dat_i,
                                        (bus_wr && wb_adr_i == OFS_EXCEPTION)
                                        ? wb_sel_i : 4'h0);
            exception_reg[OVERFLOW_POS] <= div_bad; // RL3
            exception_reg[SUMMARY_POS] <= next_summary
                | ((bus_wr && wb_adr_i == OFS_EXCEPTION && wb_sel_i[3])
                   ? wb_dat_i[SUMMARY_POS] : 1'b0); // RL22
        end else if (bus_wr && wb_adr_i == OFS_EXCEPTION) begin
            exception_reg <= lane_merge(exception_reg, wb_dat_i,
                                        wb_sel_i); // RL6
        end
    end

endmodule : idl_unit
`default_nettype wire

// ---- test/idl_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module idl_host (
    input wire logic clk_i,
    input wire logic ack_i,
    output var logic cyc_o,
    output var logic stb_o,
    output var logic we_o,
    output var idl_pkg::idl_addr_t adr_o,
    output var logic [3:0] sel_o,
    output var idl_pkg::idl_word_t dat_o,
    output var logic hung_o
);
    import idl_pkg::*;
    // Bus idle at time zero
    initial begin
        {cyc_o, stb_o, we_o, hung_o, adr_o, sel_o, dat_o} = '0;
    end
    // One classic cycle
    task automatic xfer(input logic w, input idl_addr_t a,
        input logic [3:0] s, input idl_word_t d);
        int n;
        n = 0;
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
        @(posedge clk_i);
        while (ack_i !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        hung_o <= ack_i !== 1'b1;
        {cyc_o, stb_o} <= 2'b00;
        // Idle gap
        @(posedge clk_i);
    endtask : xfer
endmodule : idl_host
`default_nettype wire

// ---- test/idl_unit_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module idl_unit_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire idl_pkg::idl_addr_t wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire idl_pkg::idl_word_t wb_dat_i,
    input wire idl_pkg::idl_word_t wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic busy_o
);
    import idl_pkg::*;
    logic take; // Request seen by the slave
    logic go; // Operation launched
    logic rd_q; // Last taken request was a read
    idl_addr_t adr_q; // Its address
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign go = take && wb_we_i && wb_adr_i == OFS_CONTROL &&
        wb_sel_i == 4'hf && !busy_o;
    // Remember what the ack answers
    always_ff @(posedge clk_i) begin
        rd_q <= take && !wb_we_i && !rst_i;
        adr_q <= wb_adr_i;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ack_next_a: assert property (take |=> wb_ack_o)
        else $error("late ack");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("long ack");
    ack_cause_a: assert property (wb_ack_o |-> $past(take))
        else $error("stray ack");
    short_op_a: assert property (go && wb_dat_i[4:0] inside
        {[5'h02:5'h16]} |=> busy_o ##1 !busy_o) else $error("op busy len");
    div_len_a: assert property (go && wb_dat_i[4:1] == 4'h0 |=>
        busy_o ##32 busy_o ##1 !busy_o) else $error("divide busy len");
    busy_cause_a: assert property ($rose(busy_o) |-> $past(go))
        else $error("stray busy");
    unmapped_zero_a: assert property (wb_ack_o && rd_q && adr_q == 8'h1c
        |-> wb_dat_o == '0) else $error("unmapped data");
    hold_data_a: assert property (!(wb_ack_o && rd_q) |-> $stable(wb_dat_o))
        else $error("data moved");
    cover property (go ##1 busy_o);
    cover property (wb_ack_o && rd_q && adr_q == OFS_RESULT);
    cover property (go && wb_dat_i[4:1] == 4'h0 ##34 !busy_o);
endmodule : idl_unit_checker
bind idl_unit idl_unit_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o));
`default_nettype wire

// ---- test/test_idl_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_idl_unit;
    import idl_pkg::*;
    typedef struct {string nm; idl_word_t v;} idl_note_s;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, busy, hung;
    logic [3:0] sel;
    idl_addr_t adr;
    idl_word_t wdat, rdat, res_m, cond_m, exc_m;
    idl_note_s exp_q[$];
    idl_note_s n;
    int miscompares = 0;
    int num_checks = 0;
    always #2.5 clk_i = ~clk_i;
    idl_host i_host (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .hung_o(hung));
    idl_unit i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .busy_o(busy));
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (miscompares == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    // Reads pop the oldest note
    always @(posedge clk_i) begin
        if (ack && !we && exp_q.size() > 0) begin
            n = exp_q.pop_front();
            `CHK(n.nm, n.v, rdat)
        end
    end
    always @(posedge hung) begin
        miscompares++;
        test_done();
    end
    task automatic chk_rd(input string nm, input idl_addr_t a,
        input idl_word_t e);
        exp_q.push_back('{nm, e});
        i_host.xfer(1'b0, a, 4'hf, '0);
    endtask : chk_rd
    task automatic wr(input idl_addr_t a, input idl_word_t d);
        i_host.xfer(1'b1, a, 4'hf, d);
    endtask : wr
    // Bounded wait for idle; a hang counts as a mismatch
    task automatic idle();
        for (int k = 0; k < 60 && busy !== 1'b0; k++) @(posedge clk_i);
        if (busy !== 1'b0) begin
            miscompares++;
            test_done();
        end
    endtask : idle
    // Reference model of results and flags
    task automatic model(input logic [4:0] op, input logic rec, ov,
        input idl_word_t s, b, output logic bad);
        idl_word_t u, h, x, r;
        u = {16'h0, b[15:0]};
        h = {b[15:0], 16'h0};
        x = op == OP_CMPI ? {{16{b[15]}}, b[15:0]} : op == OP_CMPLI ? u : b;
        r = res_m;
        bad = op <= OP_DIVWU && (b == 0 ||
            (op == OP_DIVW && s == 32'h8000_0000 && b == '1));
        case (op)
            OP_DIVW: r = $signed(s) / $signed(b);
            OP_DIVWU: r = s / b;
            OP_AND: r = s & b;
            OP_ANDI: r = s & u;
            OP_ANDIS: r = s & h;
            OP_ANDC: r = s & ~b;
            OP_NAND: r = ~(s & b);
            OP_OR: r = s | b;
            OP_ORI: r = s | u;
            OP_ORIS: r = s | h;
            OP_ORC: r = s | ~b;
            OP_NOR: r = ~(s | b);
            OP_XOR: r = s ^ b;
            OP_XORI: r = s ^ u;
            OP_XORIS: r = s ^ h;
            OP_EQUIV: r = ~(s ^ b);
            OP_EXT_BYTE: r = {{24{s[7]}}, s[7:0]};
            OP_EXT_HALF: r = {{16{s[15]}}, s[15:0]};
            OP_COUNT_ZEROS: for (int i = 0; i < 32 && !s[31 - i]; i++) r = i + 1;
            default: ;
        endcase
        if (op == OP_COUNT_ZEROS && s[31]) r = '0;
        if (op <= OP_DIVWU && ov) exc_m[31:30] = {exc_m[31] | bad, bad};
        if ((rec || op inside {OP_ANDI, OP_ANDIS}) && op < OP_CMP &&
            !(op inside {OP_ORI, OP_ORIS, OP_XORI, OP_XORIS}))
            cond_m[31:28] = {$signed(r) < 0, $signed(r) > 0, r == 0, exc_m[31]};
        if (op >= OP_CMP && op <= OP_CMPLI) cond_m[31 - 4 * b[31:29] -: 4] =
            {op <= OP_CMPI ? $signed(s) < $signed(x) : s < x,
             op <= OP_CMPI ? $signed(s) > $signed(x) : s > x, s == x, exc_m[31]};
        res_m = r;
    endtask : model
    // One operation and its checks
    task automatic run(input logic [4:0] op, input logic rec, ov,
        input idl_word_t s, b);
        logic bad;
        wr(OFS_SOURCE, s);
        wr(OFS_SECOND, b);
        wr(OFS_CONTROL, {21'h0, 1'b0, b[31:29], ov, rec, op});
        idle();
        model(op, rec, ov, s, b, bad);
        if (!bad) chk_rd("result", OFS_RESULT, res_m);
        chk_rd("condition", OFS_CONDITION, cond_m);
        chk_rd("exception", OFS_EXCEPTION, exc_m);
    endtask : run
    initial begin
        {res_m, cond_m, exc_m} = '0;
        void'($urandom(38));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk_rd("result", OFS_RESULT, '0);
        chk_rd("unmapped", 8'h1c, '0);
        wr(OFS_SOURCE, 32'h1122_3344);
        i_host.xfer(1'b1, OFS_SOURCE, 4'h5, 32'haabb_ccdd);
        chk_rd("source", OFS_SOURCE, 32'h11bb_33dd);
        // Each code three times; zero divisors tested below
        for (int i = 0; i < 69; i++) run(5'(i % 23), 1'($urandom),
            1'($urandom), $urandom, i < 23 ? 32'($urandom_range(9, 1)) : $urandom);
        // Writes while busy are dropped
        wr(OFS_SOURCE, 32'd100);
        wr(OFS_SECOND, 32'd7);
        wr(OFS_CONTROL, {27'h0, OP_DIVWU});
        wr(OFS_SOURCE, 32'd5);
        idle();
        chk_rd("source", OFS_SOURCE, 32'd100);
        chk_rd("result", OFS_RESULT, 32'd14);
        chk_rd("status", OFS_STATUS, '0);
        run(OP_DIVW, 1'b0, 1'b1, 32'h8000_0000, '1);
        run(OP_DIVWU, 1'b0, 1'b1, 32'd5, '0);
        test_done();
    end
endmodule : test_idl_unit
`default_nettype wire
